//--- addr_mode_pkg.sv
// constants and types for the operand address mode decoder
// Summary of operation
// RULE1 - codes 00000-00111 select general register 0-7 as operand, no address
// RULE2 - slave-processor instructions select auxiliary register bank instead
// RULE3 - codes 01000-01111 give displacement plus general register 0-7
// RULE4 - memory space modes add displacement to PC, SP, SB or FP
// RULE5 - 10000-10010 fetch pointer at disp1 plus FP/SP/SB, add disp2
// RULE6 - stack pointer references use the status-selected stack pointer
// RULE7 - stack select bit 0 picks stack pointer zero, 1 picks one
// RULE8 - code 10011 is reserved and never decoded as valid
// RULE9 - code 10100 takes operand from prefetch queue, no address
// RULE10 - software never uses immediate mode for written operands
// RULE11 - absolute mode address is the displacement itself
// RULE12 - external mode fetches link table pointer then adds displacement
// RULE13 - code 10110 external: disp1 is entry number, disp2 added
// RULE14 - top of stack addresses at stack pointer, pop on read, push on write
// RULE15 - scaled index allowed on any base except immediate or scaled index; the code also refuses register bases 0-7
// RULE16 - scaled index adds general register times 1, 2, 4 or 8
// RULE17 - word displacement is signed, -8192 through +8191
// RULE18 - double word displacement reaches whole address space
// RULE19 - length from top bits, rest signed, most significant byte first
// RULE20 - effective addresses wrap within 24 bits, carries dropped
package addr_mode_pkg;
   localparam int ADDR_WIDTH = 24;
   localparam logic [4:0] MODE_REG_LAST   = 5'h07;
   localparam logic [4:0] MODE_MEM_FP_REL = 5'h10;
   localparam logic [4:0] MODE_MEM_SP_REL = 5'h11;
   localparam logic [4:0] MODE_MEM_SB_REL = 5'h12;
   localparam logic [4:0] MODE_RESERVED   = 5'h13;
   localparam logic [4:0] MODE_IMMEDIATE  = 5'h14;
   localparam logic [4:0] MODE_ABSOLUTE   = 5'h15;
   localparam logic [4:0] MODE_LINK_TABLE = 5'h16;
   localparam logic [4:0] MODE_TOP_STACK  = 5'h17;
   localparam logic [4:0] MODE_FRAME_MEM  = 5'h18;
   localparam logic [4:0] MODE_STACK_MEM  = 5'h19;
   localparam logic [4:0] MODE_STATIC_MEM = 5'h1a;
   localparam logic [4:0] MODE_PROGRAM_MEM = 5'h1b;
   localparam logic [4:0] MODE_INDEX_BYTE = 5'h1c;
   localparam int LINK_ENTRY_SHIFT = 2;    // link entries are 4 bytes
   localparam int STACK_SELECT_BIT = 9;    // status bit choosing stack one
   localparam logic [31:0] STACK_STEP_RESET = 32'h0;

   // operand kind reported with each result
   typedef enum logic [2:0] {
      KIND_REGISTER  = 3'b000,
      KIND_AUX_REG   = 3'b001,
      KIND_IMMEDIATE = 3'b010,
      KIND_MEMORY    = 3'b011,
      KIND_RESERVED  = 3'b100
   } operand_kind_type;

   // decode request
   typedef struct packed {
      logic [4:0]  mode;        // general mode field
      logic [7:0]  indexByte;   // mode[7:3] base, [2:0] index register
      logic [31:0] disp1;       // raw displacement fields, msb first
      logic [31:0] disp2;
      logic        auxBank;     // slave instruction uses auxiliary bank
      logic        isWrite;     // operand will be written
      logic [1:0]  accessBytes; // log2 of operand size
   } decode_req_type;

   // decoder answer
   typedef struct packed {
      operand_kind_type      kind;
      logic [2:0]            regIndex;
      logic [ADDR_WIDTH-1:0] address;
      logic                  stackPush;
      logic                  stackPop;
      logic                  badMode;
   } decode_rsp_type;

   // decode a displacement field: value and length in bytes
   function automatic logic [31:0] disp_value(input logic [31:0] raw);
      logic [31:0] v;
      v = 32'h0;
      if (!raw[31])
         v = {{25{raw[30]}}, raw[30:24]};              // byte
      else if (!raw[30])
         v = {{18{raw[29]}}, raw[29:16]};              // word
      else
         v = {{2{raw[29]}}, raw[29:0]};                // double word
      return v;
   endfunction

   function automatic logic [2:0] disp_length(input logic [31:0] raw);
      logic [2:0] n;
      n = 3'h4;
      if (!raw[31])
         n = 3'h1;
      else if (!raw[30])
         n = 3'h2;
      return n;
   endfunction
endpackage

//--- operand_address_mode_decoder.sv
// operand addressing mode decoder with pointer fetch sequencing
`timescale 1ns/1ps
module operand_address_mode_decoder
   import addr_mode_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   // request handshake and the instruction fields
   input  wire logic                  reqValid,
   output logic                       reqReady,
   input  wire decode_req_type        req,
   // register file, dedicated pointers and status word
   input  wire logic [255:0]          generalRegs,
   input  wire logic [31:0]           programCounter,
   input  wire logic [31:0]           stack_pointer_zero,
   input  wire logic [31:0]           stack_pointer_one,
   input  wire logic [31:0]           static_base_pointer,
   input  wire logic [31:0]           frame_base_pointer,
   input  wire logic [31:0]           linkTableBase,
   input  wire logic [15:0]           processor_status_word,
   // pointer fetch from memory
   output logic                       memReadValid,
   output logic [ADDR_WIDTH-1:0]      memReadAddress,
   input  wire logic                  memReadDone,
   input  wire logic [31:0]           memReadData,
   // registered answer
   output logic                       rspValid,
   output decode_rsp_type             rsp
);
   // req is copied into held at the take, so the requester may move on;
   // the register and pointer inputs must stay put until rspValid
   // without a pointer fetch the answer comes three cycles after the take
   // with a fetch it comes two cycles after memReadDone
   // memReadValid rises only for modes that really read a pointer

   // sizes and encodings the slicing below depends on
   if (ADDR_WIDTH < 1 || ADDR_WIDTH > 32) begin : g_addr_width_check
      $error("address width must lie between 1 and 32");
   end
   if (STACK_SELECT_BIT > 15) begin : g_stack_bit_check
      $error("stack select bit lies outside the status word");
   end
   if (LINK_ENTRY_SHIFT > 3) begin : g_link_shift_check
      $error("link table entries wider than eight bytes");
   end
   if (MODE_INDEX_BYTE[1:0] != 2'b00) begin : g_index_code_check
      $error("scale factor is taken from the two low mode bits");
   end

   typedef enum logic [1:0] {
      IDLE  = 2'b00,
      FETCH = 2'b01,
      DONE  = 2'b10
   } state_type;

   state_type      state;
   decode_req_type held;
   logic [31:0]    pointer;
   state_type      next_state;

   // one 32-bit general register out of the flat register bus
   function automatic logic [31:0] reg_word(input logic [255:0] regs,
                                            input logic [2:0]   n);
      return regs[n*32 +: 32];
   endfunction

   // base mode: index byte mode when scaled, else gen field
   wire logic       scaled    = held.mode >= MODE_INDEX_BYTE;
   wire logic [4:0] baseMode  = scaled ? held.indexByte[7:3] : held.mode;
   wire logic [1:0] scalePow  = held.mode[1:0];
   wire logic [2:0] indexReg  = held.indexByte[2:0];

   // displacements arrive top-aligned with the length code on top
   wire logic [31:0] d1       = disp_value(held.disp1); // RULE17 RULE18 RULE19
   wire logic [31:0] d2       = disp_value(held.disp2); // RULE19

   // status word picks the stack for every stack reference
   wire logic       useSpOne  = processor_status_word[STACK_SELECT_BIT];
   wire logic [31:0] stackPtr = useSpOne ? stack_pointer_one
                                         : stack_pointer_zero; // RULE6 RULE7

   // general register reads for the base and the index
   wire logic [2:0] baseReg   = baseMode[2:0];
   wire logic [31:0] baseRegVal = reg_word(generalRegs, baseReg);
   wire logic [31:0] idxVal   = reg_word(generalRegs, indexReg);

   // named strobes for the single-code modes
   wire logic isReservedCode = baseMode == MODE_RESERVED;
   wire logic isImmediate    = baseMode == MODE_IMMEDIATE;
   wire logic isTopStack     = baseMode == MODE_TOP_STACK;
   wire logic isLinkMode     = baseMode == MODE_LINK_TABLE;

   // scaled index on immediate or another index is illegal
   wire logic badScale = scaled && (isImmediate ||
                         baseMode >= MODE_INDEX_BYTE);      // RULE15
   wire logic isRegMode = baseMode <= MODE_REG_LAST;
   wire logic isMemRel  = baseMode >= MODE_MEM_FP_REL &&
                          baseMode <= MODE_MEM_SB_REL;
   // a register base has no address to add an index to
   wire logic badRegScale = isRegMode && scaled;
   // only memory relative and link table modes read a pointer
   wire logic needFetch = (isMemRel || isLinkMode) && !badScale;

   // a push lands one operand size below the current stack pointer
   wire logic [31:0] stackStep   = 32'h1 << held.accessBytes;
   // index contribution, zero when no index byte is present
   wire logic [31:0] indexOffset = scaled ? (idxVal << scalePow) : 32'h0;

   // address of the pointer to fetch
   logic [31:0] fetchAddr;
   always_comb begin
      unique case (baseMode)
         MODE_MEM_FP_REL: fetchAddr = d1 + frame_base_pointer; // RULE5
         MODE_MEM_SP_REL: fetchAddr = d1 + stackPtr;           // RULE5
         MODE_MEM_SB_REL: fetchAddr = d1 + static_base_pointer; // RULE5
         // link entries are numbered, so scale the number to bytes
         default: fetchAddr = linkTableBase +
                             (d1 << LINK_ENTRY_SHIFT);         // RULE12 RULE13
      endcase
   end

   // base effective address for the non-register modes
   logic [31:0] baseEa;
   always_comb begin
      baseEa = 32'h0;
      // register relative first; fetched modes add to the pointer
      if (baseMode[4:3] == 2'b01)
         baseEa = d1 + baseRegVal;                             // RULE3
      else if (isMemRel || isLinkMode)
         baseEa = pointer + d2;                                // RULE5 RULE12
      else if (baseMode == MODE_ABSOLUTE)
         baseEa = d1;                                          // RULE11
      else if (isTopStack)
         baseEa = held.isWrite ? stackPtr - stackStep
                               : stackPtr;                     // RULE14
      else if (baseMode == MODE_FRAME_MEM)
         baseEa = d1 + frame_base_pointer;                     // RULE4
      else if (baseMode == MODE_STACK_MEM)
         baseEa = d1 + stackPtr;                               // RULE4 RULE6
      else if (baseMode == MODE_STATIC_MEM)
         baseEa = d1 + static_base_pointer;                    // RULE4
      else if (baseMode == MODE_PROGRAM_MEM)
         baseEa = d1 + programCounter;                         // RULE4
   end

   wire logic [31:0] fullEa = baseEa + indexOffset;            // RULE16

   // result assembled from the held request
   decode_rsp_type next_rsp;
   always_comb begin
      next_rsp           = '0;
      next_rsp.address   = fullEa[ADDR_WIDTH-1:0];              // RULE20
      next_rsp.kind      = KIND_MEMORY;
      next_rsp.regIndex  = baseReg;
      // bad scale and reserved code refused first, then the operand kinds with the register base refusal
      if (badScale || isReservedCode) begin
         next_rsp.kind    = KIND_RESERVED;                      // RULE8
         next_rsp.badMode = 1'b1;
         next_rsp.address = '0;
      end else if (isRegMode && !scaled) begin
         next_rsp.kind    = held.auxBank ? KIND_AUX_REG
                                         : KIND_REGISTER;       // RULE1 RULE2
         next_rsp.address = '0;
      end else if (badRegScale) begin
         next_rsp.kind    = KIND_RESERVED;                      // RULE15
         next_rsp.badMode = 1'b1;
         next_rsp.address = '0;
      end else if (isImmediate) begin
         next_rsp.kind    = KIND_IMMEDIATE;                     // RULE9
         next_rsp.address = '0;
      end else if (isTopStack) begin
         next_rsp.stackPush = held.isWrite;                     // RULE14
         next_rsp.stackPop  = !held.isWrite;
      end
   end

   // handshake outputs straight from the sequencer
   assign reqReady       = state == IDLE;
   assign memReadValid   = state == FETCH && needFetch;     // RULE1 RULE9
   assign memReadAddress = fetchAddr[ADDR_WIDTH-1:0];

   // next sequencer state; modes without a pointer pass FETCH in one cycle
   always_comb begin
      next_state = state;
      unique case (state)
         IDLE:  if (reqValid)
                   next_state = FETCH;
         FETCH: if (!needFetch || memReadDone)
                   next_state = DONE;
         DONE:  next_state = IDLE;
      endcase
   end

   // request capture and sequencing
   // held changes only at a take, so the decode stays steady
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= IDLE;
         held  <= '0;
      end else begin
         state <= next_state;
         if (reqReady && reqValid)
            held <= req;
      end
   end

   // fetched pointer and registered answer
   // pointer loads whenever memReadDone is seen in FETCH
   // rsp keeps its value between answers for a slow consumer
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pointer  <= 32'h0;
         rspValid <= 1'b0;
         rsp      <= '0;
      end else begin
         if (state == FETCH && memReadDone)
            pointer <= memReadData;
         rspValid <= state == DONE;
         if (state == DONE)
            rsp <= next_rsp;
      end
   end
endmodule

//--- addr_checker_asserts.sv
// assertions on the operand address mode decoder ports
`timescale 1ns/1ps
module addr_checker
   import addr_mode_pkg::*;
(
   input wire logic           mclk,
   input wire logic           reset_n,
   input wire logic           reqValid,
   input wire logic           reqReady,
   input wire decode_req_type req,
   input wire logic [255:0]   generalRegs,
   input wire logic           rspValid,
   input wire decode_rsp_type rsp
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   decode_req_type held;
   logic [31:0]    relSum;
   wire logic      take = reqValid && reqReady;
   // request kept from its take until the answer
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         held <= '0;
      else if (take)
         held <= req;
   end
   assign relSum = generalRegs[held.mode[2:0]*32 +: 32]
                   + disp_value(held.disp1);
   a_answer_delay: assert property (take && req.mode inside {[5'h00:5'h0f],
      [5'h13:5'h15], [5'h17:5'h1b]} |-> ##3 rspValid) else $error("late");
   a_answer_pulse: assert property (rspValid |=> !rspValid)
      else $error("answer longer than one cycle");
   a_register_kind: assert property (rspValid && held.mode <= 5'h07 &&
      !held.auxBank |-> rsp.kind == KIND_REGISTER
      && rsp.regIndex == held.mode[2:0]) else $error("register operand");
   a_aux_kind: assert property (rspValid && held.mode <= 5'h07 &&
      held.auxBank |-> rsp.kind == KIND_AUX_REG) else $error("aux bank");
   a_reserved_code: assert property (rspValid && held.mode == 5'h13
      |-> rsp.kind == KIND_RESERVED && rsp.badMode) else $error("reserved");
   a_immediate_kind: assert property (rspValid && held.mode == 5'h14
      |-> rsp.kind == KIND_IMMEDIATE) else $error("immediate");
   a_rel_address: assert property (rspValid && held.mode inside
      {[5'h08:5'h0f]} |-> rsp.address == relSum[23:0]) else $error("rel");
   a_stack_move: assert property (rspValid && held.mode == 5'h17
      |-> rsp.stackPush == held.isWrite && rsp.stackPop == !held.isWrite)
      else $error("push or pop wrong");
   c_register: cover property (take && req.mode <= 5'h07);
   c_reserved: cover property (rspValid && rsp.badMode);
   c_push: cover property (rspValid && rsp.stackPush);
endmodule
bind operand_address_mode_decoder addr_checker u_addr_checker (
   .mclk(mclk), .reset_n(reset_n), .reqValid(reqValid),
   .reqReady(reqReady), .req(req), .generalRegs(generalRegs),
   .rspValid(rspValid), .rsp(rsp));

//--- tb.sv
// self-checking bench for the operand address mode decoder
`timescale 1ns/1ps
module tb
   import addr_mode_pkg::*;
;
   logic           mclk, reset_n, reqValid, reqReady, memReadValid;
   logic           memReadDone, rspValid, fetch;
   decode_req_type req;
   decode_rsp_type rsp, e0, q[$];
   logic [255:0]   regs;
   logic [31:0]    pc, sp0, sp1, sb, fp, lt, data, seed;
   logic [15:0]    psw;
   logic [23:0]    memAddr, fq[$];
   int             n_fail, checked, i;
   operand_address_mode_decoder u_operand_address_mode_decoder (
      .mclk(mclk), .reset_n(reset_n), .reqValid(reqValid),
      .reqReady(reqReady), .req(req), .generalRegs(regs),
      .programCounter(pc), .stack_pointer_zero(sp0),
      .stack_pointer_one(sp1), .static_base_pointer(sb),
      .frame_base_pointer(fp), .linkTableBase(lt),
      .processor_status_word(psw), .memReadValid(memReadValid),
      .memReadAddress(memAddr), .memReadDone(memReadDone),
      .memReadData(data), .rspValid(rspValid), .rsp(rsp));
   always #5 mclk = ~mclk;
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function automatic logic [31:0] bd();
      logic [31:0] t;
      t = rnd();
      return {1'b0, t[6:0], 24'h0};
   endfunction
   function automatic logic [31:0] dv(input logic [31:0] r);
      if (!r[31]) return {{25{r[30]}}, r[30:24]};
      if (!r[30]) return {{18{r[29]}}, r[29:16]};
      return {{2{r[29]}}, r[29:0]};
   endfunction
   // expected pointer fetch address for a memory relative or link mode
   function automatic logic [23:0] fa(input logic [4:0] m,
                                      input logic [31:0] r1);
      logic [31:0] b;
      b = (m == 5'h10) ? fp : (m == 5'h12) ? sb : (psw[9] ? sp1 : sp0);
      if (m == 5'h16)
         b = lt + (dv(r1) << 2);
      else
         b = b + dv(r1);
      return b[23:0];
   endfunction
   // expected answer worked out from the request and the register state
   function automatic decode_rsp_type model(input decode_req_type r);
      decode_rsp_type e;
      logic [4:0]     m;
      logic [31:0]    a, s;
      e = '0;
      e.kind = KIND_MEMORY;
      m = (r.mode >= 5'h1c) ? r.indexByte[7:3] : r.mode;
      s = psw[9] ? sp1 : sp0;
      case (m)
         5'h10, 5'h11, 5'h12, 5'h16: a = data + dv(r.disp2);
         5'h13: e.kind = KIND_RESERVED;
         5'h14: e.kind = KIND_IMMEDIATE;
         5'h15: a = dv(r.disp1);
         5'h17: a = r.isWrite ? s - (32'h1 << r.accessBytes) : s;
         5'h18: a = fp + dv(r.disp1);
         5'h19: a = s + dv(r.disp1);
         5'h1a: a = sb + dv(r.disp1);
         5'h1b: a = pc + dv(r.disp1);
         default: a = regs[m[2:0]*32 +: 32] + dv(r.disp1);
      endcase
      if (m < 5'h08) begin
         e.kind = r.auxBank ? KIND_AUX_REG : KIND_REGISTER;
         e.regIndex = m[2:0];
      end
      if (r.mode >= 5'h1c) begin
         if (m < 5'h08 || m == 5'h13 || m == 5'h14 || m >= 5'h1c)
            e.kind = KIND_RESERVED;
         a = a + (regs[r.indexByte[2:0]*32 +: 32] << r.mode[1:0]);
      end
      e.badMode = (e.kind == KIND_RESERVED);
      e.address = a[23:0];
      e.stackPush = (m == 5'h17) && r.isWrite;
      e.stackPop = (m == 5'h17) && !r.isWrite;
      return e;
   endfunction
   task automatic bad(input string s);
      n_fail++;
      $display("BAD %0t %s", $time, s);
   endtask
   task automatic shuffle;
      for (int k = 0; k < 8; k++)
         regs[k*32 +: 32] = rnd();
      pc = rnd(); sp0 = rnd(); sp1 = rnd(); sb = rnd();
      fp = rnd(); lt = rnd(); data = rnd(); psw = 16'(rnd());
   endtask
   // one request: note expectation, drive, wait for the answer
   task automatic send(input logic [4:0] md, input logic [7:0] ix,
                       input logic [31:0] d1, d2, input logic [1:0] wa);
      decode_req_type r;
      int             k;
      logic [4:0]     bm;
      shuffle();
      r = '{md, ix, d1, d2, wa[1], wa[0], psw[1:0]};
      q.push_back(model(r));
      bm = (md >= 5'h1c) ? ix[7:3] : md;
      fetch = bm inside {5'h10, 5'h11, 5'h12, 5'h16};
      if (fetch)
         fq.push_back(fa(bm, d1));
      req = r;
      reqValid = 1'b1;
      @(negedge mclk);
      reqValid = 1'b0;
      k = 0;
      while (reqReady !== 1'b1 && k < 40) begin
         @(negedge mclk);
         k++;
      end
      if (k == 40) bad("no answer");
      @(negedge mclk);
   endtask
   task automatic complete_run;
      if (q.size() != 0 || fq.size() != 0)
         bad("expected results left over");
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // pointer fetch answered at the next falling edge, half a cycle after it is asked for
   always @(negedge mclk) memReadDone <= memReadValid && fetch && !memReadDone;
   // every pointer fetch is expected and goes to the expected address
   always @(negedge mclk) begin
      if (reset_n && memReadValid === 1'b1 && !memReadDone) begin
         if (!fetch || fq.size() == 0)
            bad("fetch without a pointer mode");
         else begin
            checked++;
            if (memAddr !== fq.pop_front())
               bad("fetch address differs");
         end
      end
   end
   // answer watcher
   always @(posedge mclk) begin
      if (reset_n && rspValid === 1'b1) begin
         if (q.size() == 0) bad("extra answer");
         else begin
            e0 = q.pop_front();
            checked++;
            if (rsp.kind !== e0.kind || rsp.badMode !== e0.badMode
                || (e0.kind inside {KIND_REGISTER, KIND_AUX_REG}
                    && rsp.regIndex !== e0.regIndex)
                || (e0.kind == KIND_MEMORY && (rsp.address !== e0.address
                    || rsp.stackPush !== e0.stackPush
                    || rsp.stackPop !== e0.stackPop)))
               bad("answer differs");
         end
      end
   end
   initial begin
      mclk = 1'b0; reset_n = 1'b0; reqValid = 1'b0; memReadDone = 1'b0;
      fetch = 1'b0; seed = 32'habc0563f; n_fail = 0; checked = 0;
      req = '0;
      shuffle();
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      reset_n = 1'b1;
      for (i = 0; i < 16; i++)
         send(i[4:0], 8'h0, bd(), 32'h0, i[1:0]);
      send(5'h0b, 8'h0, 32'ha0000000, 32'h0, 2'h0);
      send(5'h0c, 8'h0, 32'h9fff0000, 32'h0, 2'h0);
      $display("register modes done");
      for (i = 5'h18; i < 5'h1c; i++)
         repeat (2) send(i[4:0], 8'h0, bd(), 32'h0, 2'h0);
      for (i = 5'h10; i < 5'h13; i++)
         send(i[4:0], 8'h0, bd(), bd(), 2'h0);
      send(5'h13, 8'h0, bd(), 32'h0, 2'h0);
      send(5'h14, 8'h0, 32'h0, 32'h0, 2'h0);
      send(5'h15, 8'h0, 32'hc0fedcba, 32'h0, 2'h0);
      send(5'h16, 8'h0, bd(), bd(), 2'h0);
      for (i = 0; i < 4; i++)
         send(5'h17, 8'h0, 32'h0, 32'h0, i[1:0]);
      $display("memory modes done");
      for (i = 5'h1c; i < 5'h20; i++)
         send(i[4:0], {5'h09, i[2:0]}, bd(), 32'h0, 2'h0);
      send(5'h1d, {5'h14, 3'h2}, 32'h0, 32'h0, 2'h0);
      send(5'h1e, {5'h1f, 3'h2}, 32'h0, 32'h0, 2'h0);
      send(5'h1c, {5'h03, 3'h1}, 32'h0, 32'h0, 2'h0);
      send(5'h1f, {5'h11, 3'h5}, bd(), bd(), 2'h0);
      $display("scaled index done");
      complete_run();
   end
   initial begin
      #100000;
      bad("timeout");
      complete_run();
   end
endmodule
